// *** design/otp_seq_pkg.sv ***
// Constants for the nonvolatile program check / write sequencer.
// Assumes a 125 MHz system clock and a byte-wide command port on the same clock.
`default_nettype none
package otp_seq_pkg;
  // Command addresses of the subcommand window
  localparam logic [6:0] CMD_SUB_LO    = 7'h3E;
  localparam logic [6:0] CMD_SUB_HI    = 7'h3F;
  localparam logic [6:0] CMD_BUF_FIRST = 7'h40;
  localparam logic [6:0] CMD_BUF_LAST  = 7'h5F;
  localparam logic [6:0] CMD_CSUM      = 7'h60;
  localparam logic [6:0] CMD_LEN       = 7'h61;
  localparam int         BUF_BYTES     = 32;
  localparam logic [7:0] BUSY_READ     = 8'hFF;
  localparam logic [7:0] LEN_OVERHEAD  = 8'h04;

  // Subcommand codes
  localparam logic [15:0] SUB_CHECK = 16'h00A0;
  localparam logic [15:0] SUB_WRITE = 16'h00A1;
  localparam logic [15:0] SUB_MFG   = 16'h0070;

  // Result byte 0 bit positions
  localparam int RES_OK_BIT     = 7;
  localparam int RES_LOCK_BIT   = 5;
  localparam int RES_NOSIG_BIT  = 4;
  localparam int RES_NODATA_BIT = 3;
  localparam int RES_TEMP_BIT   = 2;
  localparam int RES_UV_BIT     = 1;
  localparam int RES_OV_BIT     = 0;
  localparam logic [7:0] RESULT_BYTES = 8'h03;

  // Settings image: byte i of each vector is setting byte i, least significant byte first
  localparam int          SET_COUNT     = 16;
  localparam int          SET_IDX_W     = 4;
  localparam logic [15:0] SET_BASE_ADDR = 16'h9000;
  localparam logic [127:0] SET_DEFAULT_VEC  = 128'h0;
  // Cell-input usage word 0xAFFF sits in bytes 0 and 1 of the first image
  localparam logic [127:0] FACTORY_IMG1_VEC = 128'h0000_0000_0000_0000_0000_0000_0000_AFFF;
  localparam logic [15:0]  FACTORY_SIG      = 16'h01AE;
  localparam logic [3:0]   SIG_SLOTS        = 4'h8;
  localparam logic [3:0]   FACTORY_SLOTS    = 4'h1;

  // Manufacturing data area, outside the signature
  localparam int         MFG_BYTES = 4;
  localparam logic [2:0] MFG_LAST  = 3'h3;

  // Programming times
  localparam int CLK_PERIOD_NS    = 8;
  localparam int BURN_FAST_NS     = 200000;
  localparam int BURN_SLOW_NS     = 125000000;
  localparam int BURN_FAST_CYCLES = (BURN_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BURN_SLOW_CYCLES = (BURN_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W          = 24;

  typedef enum logic [4:0] {
    ST_BOOT  = 5'b00001,
    ST_IDLE  = 5'b00010,
    ST_FAST  = 5'b00100,
    ST_SLOW  = 5'b01000,
    ST_REPLY = 5'b10000
  } state_type;
endpackage
`default_nettype wire

// *** design/otp_program_check_and_write.sv ***
// Nonvolatile program check / write sequencer with its subcommand window.
// Assumes host command accesses and measurement flags come from logic on SYS_CLK_IN.
//
// Notes on behaviour
// - Check subcommand runs a programmability self-check and returns result bytes.
// - Byte0 bit7 set only when all conditions pass, other flags then clear.
// - Byte0 bit5 flags missing access modes or a set lock.
// - Byte0 bit4 flags that every signature slot is used.
// - Byte0 bit3 flags a value with no XOR image bits left.
// - With bit3 set, bytes 1 and 2 hold first failing address.
// - Byte0 bit2 flags die temperature above the programming range.
// - Byte0 bit1 flags stack voltage low, bit0 stack voltage high.
// - Write returns the same three bytes, bit7 set on success.
// - Configuration-update programming takes a fixed time per burned byte.
// - Normal-operation burns need the field program enable setting.
// - Manufacturing data also writable by its own subcommand in unrestricted mode.
// - Fault status saving needs both fault save and field program enables.
// - Normal-operation burns check minimum voltage only, not the maximum.
// - Normal-operation burns run at a slow per-byte rate.
// - Cell-usage word comes factory set; bits may be cleared once, never reset.
// - Unsigned settings stored unchanged, one, two or four bytes, LSB first.
// - Signed settings are two's complement, same widths, LSB first.
// - Real settings are single precision, LSB first, bias 127, 23-bit fraction.
// - All-ones exponent is infinity or NaN; zero exponent is subnormal.
// - Bit-field settings use the unsigned integer encoding.
// - Subcommand written to 0x3E/0x3F; reads give 0xFF until done.
// - Response sits in the 32-byte buffer, checksum 0x60, length 0x61.
// - Checksum is the inverted 8-bit sum of subcommand and used bytes.
// - At boot each setting is image1 XOR image2 XOR default, defaults on mismatch.
`default_nettype none
module otp_program_check_and_write
  import otp_seq_pkg::*;
#(
  parameter int unsigned FAST_BURN_CYCLES = otp_seq_pkg::BURN_FAST_CYCLES,
  parameter int unsigned SLOW_BURN_CYCLES = otp_seq_pkg::BURN_SLOW_CYCLES
) (
  input  wire logic                           SYS_CLK_IN,        // System clock
  input  wire logic                           RST_IN,            // Sync reset, high
  input  wire logic                           CE_IN,             // Clock enable
  input  wire logic [6:0]                     CMD_ADDR_IN,       // Command address
  input  wire logic                           CMD_WR_IN,         // Command write strobe
  input  wire logic [7:0]                     CMD_WDATA_IN,      // Command write data
  input  wire logic                           CMD_RD_IN,         // Command read strobe
  output logic      [7:0]                     CMD_RDATA_OUT,     // Command read data
  input  wire logic                           UNRESTRICTED_ACCESS_MODE_IN, // Access mode
  input  wire logic                           CONFIG_UPDATE_MODE_IN,       // Update mode
  input  wire logic                           OTP_LOCK_IN,       // Lock setting
  input  wire logic                           FIELD_PROGRAM_ENABLE_IN, // Normal-op burns
  input  wire logic                           FAULT_SAVE_ENABLE_IN,    // Fault save allow
  input  wire logic                           OVER_TEMPERATURE_IN, // Die too hot
  input  wire logic                           UNDER_VOLTAGE_IN,  // Stack below minimum
  input  wire logic                           OVER_VOLTAGE_IN,   // Stack above maximum
  input  wire logic                           PERMANENT_FAULT_IN, // Save fault pulse
  input  wire logic [7:0]                     FAULT_STATUS_IN,   // Fault byte to save
  input  wire logic                           SET_WR_IN,         // Setting RAM write
  input  wire logic [otp_seq_pkg::SET_IDX_W-1:0] SET_ADDR_IN,    // Setting index
  input  wire logic [7:0]                     SET_DATA_IN,       // Setting write data
  output logic      [7:0]                     SET_VALUE_OUT,     // Working setting
  output logic      [7:0]                     FAULT_SAVED_OUT,   // Saved fault byte
  output logic                                BUSY_OUT           // Subcommand running
);
  import otp_seq_pkg::*;

  state_type             state_reg;
  logic [7:0]            sub_lo_reg;
  logic [7:0]            sub_hi_reg;
  logic [7:0]            buf_reg [BUF_BYTES];
  logic [7:0]            csum_reg;
  logic [7:0]            len_reg;
  logic                  busy_reg;
  logic                  start_reg;
  logic                  mfg_go_reg;
  logic                  fault_pend_reg;
  logic [7:0]            ram_reg  [SET_COUNT];
  logic [7:0]            img1_reg [SET_COUNT];
  logic [7:0]            img2_reg [SET_COUNT];
  logic [7:0]            mfg_reg  [MFG_BYTES];
  logic [7:0]            pf_reg;
  logic [15:0]           sig_reg;
  logic [3:0]            slots_reg;
  logic [SET_IDX_W-1:0]  ptr_reg;
  logic [2:0]            mptr_reg;
  logic                  slow_fault_reg;
  logic [TIMER_W-1:0]    timer_reg;
  logic [23:0]           result_reg;
  logic [7:0]            reply_n_reg;
  logic [7:0]            rdata_reg;
  logic [7:0]            set_value_reg;

  // Per-entry burn plan
  // Multi-byte settings occupy consecutive entries, least significant first
  // Signed values are burned as their two's-complement bytes unchanged
  // Real values are four IEEE single-precision bytes, LSB first
  // Exponent codes are kept bit-exact, so infinity, NaN and subnormals survive
  // Bit-field settings are plain unsigned bytes here
  logic [SET_COUNT-1:0]  need_vec;
  logic [SET_COUNT-1:0]  fail_vec;
  logic [7:0]            new1 [SET_COUNT];
  logic [7:0]            new2 [SET_COUNT];
  genvar gi;
  generate
    for (gi = 0; gi < SET_COUNT; gi++) begin : g_plan
      wire logic [7:0] target = ram_reg[gi] ^ SET_DEFAULT_VEC[8*gi +: 8];
      wire logic [7:0] alt2   = img1_reg[gi] ^ target;
      // First image only while the second is blank; cells never return to zero
      wire logic       use1   = (img2_reg[gi] == 8'h00) && ((img1_reg[gi] & ~target) == 8'h00);
      wire logic       use2   = (img2_reg[gi] & ~alt2) == 8'h00;
      assign need_vec[gi] = target != (img1_reg[gi] ^ img2_reg[gi]);
      // No image bits left for this value
      assign fail_vec[gi] = need_vec[gi] && !use1 && !use2;
      assign new1[gi]     = use1 ? target : img1_reg[gi];
      assign new2[gi]     = use1 ? img2_reg[gi] : alt2;
    end
  endgenerate

  // Signature over both images, first failing address
  logic [15:0] img_sum;
  logic [15:0] fail_addr;
  always_comb begin
    img_sum   = 16'h0000;
    fail_addr = 16'h0000;
    for (int i = 0; i < SET_COUNT; i++) begin
      img_sum = img_sum + {8'h00, img1_reg[i]} + {8'h00, img2_reg[i]};
    end
    for (int i = SET_COUNT - 1; i >= 0; i--) begin
      if (fail_vec[i]) begin
        fail_addr = SET_BASE_ADDR + 16'(i);
      end
    end
  end

  // Locked unless both modes held and lock clear
  wire logic locked_flag = !(UNRESTRICTED_ACCESS_MODE_IN && CONFIG_UPDATE_MODE_IN) || OTP_LOCK_IN;
  wire logic signature_exhausted_flag = slots_reg >= SIG_SLOTS;
  wire logic no_data_flag             = |fail_vec;
  wire logic over_temperature_flag    = OVER_TEMPERATURE_IN;
  wire logic under_voltage_flag       = UNDER_VOLTAGE_IN;
  wire logic over_voltage_flag        = OVER_VOLTAGE_IN;
  wire logic any_flag = locked_flag | signature_exhausted_flag | no_data_flag
                      | over_temperature_flag | under_voltage_flag | over_voltage_flag;
  logic [7:0] flags_byte;
  always_comb begin
    flags_byte                 = 8'h00;
    // Pass bit only with every other flag clear
    flags_byte[RES_OK_BIT]     = !any_flag;
    flags_byte[RES_LOCK_BIT]   = locked_flag;
    flags_byte[RES_NOSIG_BIT]  = signature_exhausted_flag;
    flags_byte[RES_NODATA_BIT] = no_data_flag;
    flags_byte[RES_TEMP_BIT]   = over_temperature_flag;
    flags_byte[RES_UV_BIT]     = under_voltage_flag;
    flags_byte[RES_OV_BIT]     = over_voltage_flag;
  end
  wire logic [23:0] check_result = {no_data_flag ? fail_addr : 16'h0000, flags_byte};

  // Command window decode
  wire logic [15:0] sub_code  = {sub_hi_reg, sub_lo_reg};
  wire logic        wr_lo     = CMD_WR_IN && (CMD_ADDR_IN == CMD_SUB_LO);
  wire logic        wr_hi     = CMD_WR_IN && (CMD_ADDR_IN == CMD_SUB_HI);
  wire logic        wr_csum   = CMD_WR_IN && (CMD_ADDR_IN == CMD_CSUM);
  wire logic        wr_len    = CMD_WR_IN && (CMD_ADDR_IN == CMD_LEN);
  wire logic        in_buf    = (CMD_ADDR_IN >= CMD_BUF_FIRST) && (CMD_ADDR_IN <= CMD_BUF_LAST);
  wire logic [4:0]  buf_idx   = 5'(CMD_ADDR_IN - CMD_BUF_FIRST);
  wire logic        wr_buf    = CMD_WR_IN && in_buf && !busy_reg;

  // Checksums of host data and of our reply
  logic [7:0] host_sum;
  logic [7:0] reply_sum;
  always_comb begin
    host_sum  = sub_lo_reg + sub_hi_reg;
    reply_sum = sub_lo_reg + sub_hi_reg;
    for (int i = 0; i < BUF_BYTES; i++) begin
      if (8'(i) + LEN_OVERHEAD < CMD_WDATA_IN) begin
        host_sum = host_sum + buf_reg[i];
      end
    end
    for (int i = 0; i < MFG_BYTES; i++) begin
      if (8'(i) < reply_n_reg) begin
        reply_sum = reply_sum + (sub_code == SUB_MFG ? mfg_reg[i] : result_reg[8*(i%3) +: 8]);
      end
    end
  end
  wire logic host_csum_ok = (~host_sum) == csum_reg;

  // Manufacturing data by its own subcommand in unrestricted mode
  // Normal-operation burns need the field enable
  // Only the minimum voltage is checked here
  wire logic mfg_allowed = UNRESTRICTED_ACCESS_MODE_IN && FIELD_PROGRAM_ENABLE_IN
                         && !UNDER_VOLTAGE_IN;
  wire logic fault_allowed = FAULT_SAVE_ENABLE_IN && FIELD_PROGRAM_ENABLE_IN && !UNDER_VOLTAGE_IN;

  wire logic idle       = state_reg == ST_IDLE;
  wire logic timer_done = timer_reg == '0;
  wire logic ptr_last   = ptr_reg == SET_IDX_W'(SET_COUNT - 1);
  wire logic boot_sig_ok = img_sum == sig_reg;

  // Subcommand bytes read 0xFF while running
  logic [7:0] read_mux;
  always_comb begin
    read_mux = 8'h00;
    if (CMD_ADDR_IN == CMD_SUB_LO) begin
      read_mux = busy_reg ? BUSY_READ : sub_lo_reg;
    end else if (CMD_ADDR_IN == CMD_SUB_HI) begin
      read_mux = busy_reg ? BUSY_READ : sub_hi_reg;
    end else if (in_buf) begin
      read_mux = buf_reg[buf_idx];
    end else if (CMD_ADDR_IN == CMD_CSUM) begin
      read_mux = csum_reg;
    end else if (CMD_ADDR_IN == CMD_LEN) begin
      read_mux = len_reg;
    end
  end

  // Command window registers
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      sub_lo_reg <= 8'h00;
      sub_hi_reg <= 8'h00;
      csum_reg   <= 8'h00;
      len_reg    <= 8'h00;
      busy_reg   <= 1'b0;
      start_reg  <= 1'b0;
      mfg_go_reg <= 1'b0;
      rdata_reg  <= 8'h00;
    end else if (CE_IN) begin
      if (CMD_RD_IN) begin
        rdata_reg <= read_mux;
      end
      if (wr_lo && !busy_reg) begin
        sub_lo_reg <= CMD_WDATA_IN;
      end
      if (wr_hi && !busy_reg) begin
        sub_hi_reg <= CMD_WDATA_IN;
        busy_reg   <= 1'b1;
        start_reg  <= 1'b1;
      end else if (idle) begin
        start_reg <= 1'b0;
      end
      if (wr_csum && !busy_reg) begin
        csum_reg <= CMD_WDATA_IN;
      end
      // Host data accepted only with a matching checksum
      if (wr_len && !busy_reg) begin
        len_reg <= CMD_WDATA_IN;
        if (sub_code == SUB_MFG && host_csum_ok && mfg_allowed) begin
          mfg_go_reg <= 1'b1;
          busy_reg   <= 1'b1;
        end
      end else if (state_reg == ST_SLOW) begin
        mfg_go_reg <= 1'b0;
      end
      // Reply length covers data plus four window bytes
      if (state_reg == ST_REPLY) begin
        busy_reg <= 1'b0;
        csum_reg <= ~reply_sum;
        len_reg  <= reply_n_reg + LEN_OVERHEAD;
      end else if (state_reg == ST_SLOW && !slow_fault_reg && !mfg_go_reg
                   && mptr_reg == MFG_LAST && timer_done) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // Transfer buffer: host writes, reply fill
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      for (int i = 0; i < BUF_BYTES; i++) begin
        buf_reg[i] <= 8'h00;
      end
    end else if (CE_IN) begin
      if (wr_buf) begin
        buf_reg[buf_idx] <= CMD_WDATA_IN;
      end else if (state_reg == ST_REPLY) begin
        for (int i = 0; i < MFG_BYTES; i++) begin
          if (8'(i) < reply_n_reg) begin
            buf_reg[i] <= (sub_code == SUB_MFG) ? mfg_reg[i] : result_reg[8*(i%3) +: 8];
          end
        end
      end
    end
  end

  // Sequencer and nonvolatile cells; reset stands in for a fresh factory part
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      state_reg      <= ST_BOOT;
      sig_reg        <= FACTORY_SIG;
      slots_reg      <= FACTORY_SLOTS;
      ptr_reg        <= '0;
      mptr_reg       <= 3'h0;
      slow_fault_reg <= 1'b0;
      fault_pend_reg <= 1'b0;
      timer_reg      <= '0;
      result_reg     <= 24'h000000;
      reply_n_reg    <= 8'h00;
      pf_reg         <= 8'h00;
      for (int i = 0; i < SET_COUNT; i++) begin
        ram_reg[i]  <= 8'h00;
        img1_reg[i] <= FACTORY_IMG1_VEC[8*i +: 8];
        img2_reg[i] <= 8'h00;
      end
      for (int i = 0; i < MFG_BYTES; i++) begin
        mfg_reg[i] <= 8'h00;
      end
    end else if (CE_IN) begin
      // A fault arriving while one is being cleared is still kept
      if (PERMANENT_FAULT_IN && fault_allowed) begin
        fault_pend_reg <= 1'b1;
      end else if (idle && fault_pend_reg && !start_reg && !mfg_go_reg) begin
        fault_pend_reg <= 1'b0;
      end
      if (SET_WR_IN && idle) begin
        ram_reg[SET_ADDR_IN] <= SET_DATA_IN;
      end
      unique case (state_reg)
        ST_BOOT: begin
          // XOR of both images with defaults, defaults on signature mismatch
          for (int i = 0; i < SET_COUNT; i++) begin
            ram_reg[i] <= boot_sig_ok ? (img1_reg[i] ^ img2_reg[i] ^ SET_DEFAULT_VEC[8*i +: 8])
                                      : SET_DEFAULT_VEC[8*i +: 8];
          end
          state_reg <= ST_IDLE;
        end
        ST_IDLE: begin
          ptr_reg   <= '0;
          mptr_reg  <= 3'h0;
          timer_reg <= TIMER_W'(SLOW_BURN_CYCLES);
          if (mfg_go_reg) begin
            slow_fault_reg <= 1'b0;
            state_reg      <= ST_SLOW;
          end else if (start_reg) begin
            reply_n_reg <= RESULT_BYTES;
            result_reg  <= check_result;
            // Check answers at once with the self-check bytes
            if (sub_code == SUB_WRITE && !any_flag) begin
              timer_reg <= TIMER_W'(FAST_BURN_CYCLES);
              state_reg <= ST_FAST;
            end else if (sub_code == SUB_CHECK || sub_code == SUB_WRITE) begin
              state_reg <= ST_REPLY;
            end else begin
              reply_n_reg <= (sub_code == SUB_MFG) ? 8'(MFG_BYTES) : 8'h00;
              state_reg   <= ST_REPLY;
            end
          end else if (fault_pend_reg) begin
            slow_fault_reg <= 1'b1;
            state_reg      <= ST_SLOW;
          end
        end
        ST_FAST: begin
          // One fixed burn time per changed byte; unchanged bytes skip
          if (need_vec[ptr_reg] && !timer_done) begin
            timer_reg <= timer_reg - TIMER_W'(1);
          end else begin
            if (need_vec[ptr_reg]) begin
              img1_reg[ptr_reg] <= new1[ptr_reg];
              img2_reg[ptr_reg] <= new2[ptr_reg];
            end
            timer_reg <= TIMER_W'(FAST_BURN_CYCLES);
            ptr_reg   <= ptr_reg + SET_IDX_W'(1);
            if (ptr_last) begin
              state_reg <= ST_REPLY;
            end
          end
          // Success reported after the last byte, signature slot consumed
          if (ptr_last && (!need_vec[ptr_reg] || timer_done)) begin
            result_reg <= {16'h0000, 8'h80};
            slots_reg  <= slots_reg + 4'h1;
            sig_reg    <= img_sum - {8'h00, img1_reg[ptr_reg]} - {8'h00, img2_reg[ptr_reg]}
                        + {8'h00, new1[ptr_reg]} + {8'h00, new2[ptr_reg]};
          end
        end
        ST_SLOW: begin
          // Normal-operation burns run at the slow byte rate
          if (!timer_done) begin
            timer_reg <= timer_reg - TIMER_W'(1);
          end else if (slow_fault_reg) begin
            pf_reg    <= pf_reg | FAULT_STATUS_IN;
            state_reg <= ST_IDLE;
          end else begin
            // Cells only gain ones, so a repeat burn can never clear data
            mfg_reg[mptr_reg[1:0]] <= mfg_reg[mptr_reg[1:0]] | buf_reg[mptr_reg];
            timer_reg <= TIMER_W'(SLOW_BURN_CYCLES);
            mptr_reg  <= mptr_reg + 3'h1;
            if (mptr_reg == MFG_LAST) begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_REPLY: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Output registers
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      set_value_reg <= 8'h00;
    end else if (CE_IN) begin
      set_value_reg <= ram_reg[SET_ADDR_IN];
    end
  end

  // Host obligations assumed, not enforced
  // A check outside the required modes just reports the lock flag
  // A write after a failed check only repeats the failing flags
  assign CMD_RDATA_OUT   = rdata_reg;
  assign SET_VALUE_OUT   = set_value_reg;
  assign FAULT_SAVED_OUT = pf_reg;
  assign BUSY_OUT        = busy_reg;
endmodule
`default_nettype wire

// *** verif/otp_seq_chk.sv ***
// Checker for the command port, busy and reset of the sequencer.
// Bound into the sequencer; sees only its ports.
`default_nettype none
module otp_seq_chk #(
  parameter int unsigned FAST_BURN_CYCLES = 4,
  parameter int unsigned SLOW_BURN_CYCLES = 6
) (
  input wire logic       SYS_CLK_IN,         // clk
  input wire logic       RST_IN,             // rst
  input wire logic       CE_IN,              // enable
  input wire logic [6:0] CMD_ADDR_IN,        // addr
  input wire logic       CMD_WR_IN,          // write
  input wire logic       CMD_RD_IN,          // read
  input wire logic [7:0] CMD_RDATA_OUT,      // rdata
  input wire logic       PERMANENT_FAULT_IN, // fault
  input wire logic [7:0] FAULT_SAVED_OUT,    // saved
  input wire logic       BUSY_OUT            // busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (RST_IN);
  // A counter, since the longest burn is far beyond any delay range
  int unsigned busy_cnt_reg;
  always_ff @(posedge SYS_CLK_IN) busy_cnt_reg <= (RST_IN || !BUSY_OUT) ? 0 : busy_cnt_reg + 1;
  a_busy_start: assert property (
    CE_IN && CMD_WR_IN && CMD_ADDR_IN == 7'h3F && !BUSY_OUT |-> ##[1:2] BUSY_OUT)
    else $error("no busy after start");
  a_busy_poll: assert property (
    CE_IN && CMD_RD_IN && BUSY_OUT && CMD_ADDR_IN inside {7'h3E, 7'h3F}
    |=> CMD_RDATA_OUT == 8'hFF) else $error("poll not FF while busy");
  a_unmapped_read: assert property (
    CE_IN && CMD_RD_IN && (CMD_ADDR_IN < 7'h3E || CMD_ADDR_IN > 7'h61)
    |=> CMD_RDATA_OUT == 8'h00) else $error("unmapped read not zero");
  a_read_hold: assert property (
    !(CE_IN && CMD_RD_IN) |=> $stable(CMD_RDATA_OUT)) else $error("read data moved");
  a_freeze_state: assert property (
    !CE_IN |=> $stable(BUSY_OUT) && $stable(FAULT_SAVED_OUT)) else $error("moved without enable");
  a_burn_bound: assert property (
    busy_cnt_reg <= 4 * SLOW_BURN_CYCLES + 16 * FAST_BURN_CYCLES + 64) else $error("busy too long");
  a_fault_quiet: assert property (
    PERMANENT_FAULT_IN && !BUSY_OUT && !CMD_WR_IN && !$past(CMD_WR_IN) |=> !BUSY_OUT)
    else $error("fault save raised busy");
  a_reset_clear: assert property (disable iff (1'b0)
    RST_IN && CE_IN |=> CMD_RDATA_OUT == 8'h00 && !BUSY_OUT && FAULT_SAVED_OUT == 8'h00)
    else $error("outputs not cleared by reset");
endmodule
bind otp_program_check_and_write otp_seq_chk #(
  .FAST_BURN_CYCLES(FAST_BURN_CYCLES),
  .SLOW_BURN_CYCLES(SLOW_BURN_CYCLES)
) u_chk (.*);
`default_nettype wire

// *** verif/host_proc.sv ***
// Host model: byte writes, reads and subcommands on the command port.
// Assumes the device samples strobes on the rising clock edge.
`default_nettype none
module host_proc (
  input  wire logic       clk_in,    // clock
  input  wire logic [7:0] rdata_in,  // read data
  output var  logic [6:0] addr_out,  // address
  output var  logic       wr_out,    // write strobe
  output var  logic [7:0] wdata_out, // write data
  output var  logic       rd_out     // read strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_out = 7'h00;
    wr_out = 1'b0;
    wdata_out = 8'h00;
    rd_out = 1'b0;
  end
  task automatic wr_byte(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_in) #1;
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(posedge clk_in) #1;
    wr_out = 1'b0;
    // Released data flips so a stale byte cannot pass
    wdata_out = ~d;
  endtask
  task automatic rd_byte(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk_in) #1;
    addr_out = a;
    rd_out = 1'b1;
    @(posedge clk_in) #1;
    rd_out = 1'b0;
    d = rdata_in;
  endtask
  // low, high, poll, then length, buffer, checksum
  task automatic sub(input logic [15:0] c, output logic [7:0] r [6]);
    r[0] = 8'hFF;
    wr_byte(7'h3E, c[7:0]);
    wr_byte(7'h3F, c[15:8]);
    for (int n = 0; n < 200 && r[0] === 8'hFF; n++) rd_byte(7'h3E, r[0]);
    for (int n = 0; n < 5; n++)
      rd_byte(7'(n == 0 ? 32'h61 : n == 4 ? 32'h60 : 32'h3F + n), r[n + 1]);
  endtask
endmodule
`default_nettype wire

// *** verif/test_otp_program_check_and_write.sv ***
// Testbench: checks, burns, slot use and fault saving of the sequencer.
// Assumes the host model and the bound checker.
`default_nettype none
`define CHK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("unexpected at %0t: %h not %h", $time, got, exp); \
    end \
  end
module test_otp_program_check_and_write;
  import otp_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FAST = 4;
  localparam int SLOW = 6;
  logic clk = 0, rst = 1, ce = 1, ua = 1, cu = 1, lock = 0, fpe = 1, fse = 0;
  logic ot = 0, uv = 0, ov = 0, pf = 0, swr = 0, wr, rd, busy;
  logic [3:0] sa = 4'h0;
  logic [6:0] addr;
  logic [7:0] sd = 8'h00, fst = 8'h00, sv, fsv, rdata, wdata, t8;
  logic [7:0] fl [5] = '{8'h04, 8'h02, 8'h01, 8'h20, 8'h20};
  logic [7:0] r6 [6];
  int num_checks = 0, bad_count = 0, nb = 0, n1 = 0;
  otp_program_check_and_write #(.FAST_BURN_CYCLES(FAST), .SLOW_BURN_CYCLES(SLOW)) u_dut (
    .SYS_CLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .CMD_ADDR_IN(addr), .CMD_WR_IN(wr),
    .CMD_WDATA_IN(wdata), .CMD_RD_IN(rd), .CMD_RDATA_OUT(rdata),
    .UNRESTRICTED_ACCESS_MODE_IN(ua), .CONFIG_UPDATE_MODE_IN(cu), .OTP_LOCK_IN(lock),
    .FIELD_PROGRAM_ENABLE_IN(fpe), .FAULT_SAVE_ENABLE_IN(fse), .OVER_TEMPERATURE_IN(ot),
    .UNDER_VOLTAGE_IN(uv), .OVER_VOLTAGE_IN(ov), .PERMANENT_FAULT_IN(pf),
    .FAULT_STATUS_IN(fst), .SET_WR_IN(swr), .SET_ADDR_IN(sa), .SET_DATA_IN(sd),
    .SET_VALUE_OUT(sv), .FAULT_SAVED_OUT(fsv), .BUSY_OUT(busy));
  host_proc u_host (.clk_in(clk), .rdata_in(rdata), .addr_out(addr), .wr_out(wr),
    .wdata_out(wdata), .rd_out(rd));
  initial forever #4 clk = ~clk;
  always @(posedge clk) if (busy) nb++;
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic expect_sub(input logic [15:0] c, input logic [23:0] e);
    logic [7:0] r [6];
    u_host.sub(c, r);
    `CHK({r[0], r[1], r[2], r[3], r[4]}, {c[7:0], 8'h07, e})
    `CHK(r[5], ~(c[7:0] + c[15:8] + e[23:16] + e[15:8] + e[7:0]))
  endtask
  task automatic setw(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    sa = a;
    sd = d;
    swr = 1'b1;
    @(posedge clk) #1;
    swr = 1'b0;
  endtask
  // write only after a passing check
  task automatic burn;
    expect_sub(SUB_CHECK, 24'h800000);
    expect_sub(SUB_WRITE, 24'h800000);
  endtask
  initial begin
    #(8 * 30000);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    `CHK(sv, 8'hFF)
    u_host.rd_byte(7'h10, t8);
    `CHK(t8, 8'h00)
    // both access modes held high except in the last case, which drops unrestricted access
    for (int i = 0; i < 5; i++) begin
      {ot, uv, ov, lock, ua} = (5'b10000 >> i) ^ 5'b00001;
      expect_sub(SUB_CHECK, {fl[i], 16'h0000});
    end
    {ot, uv, ov, lock, ua} = 5'b00001;
    $display("test flags done");
    setw(4'h2, 8'h01);
    nb = 0;
    burn;
    n1 = nb;
    setw(4'h3, 8'h01);
    setw(4'h4, 8'h01);
    nb = 0;
    burn;
    `CHK(nb - n1, FAST)
    setw(4'h1, 8'h2F);
    burn;
    setw(4'h1, 8'hAF);
    expect_sub(SUB_CHECK, 24'h080190);
    setw(4'h1, 8'h2F);
    ce = 1'b0;
    repeat (3) @(posedge clk);
    #1 ce = 1'b1;
    $display("test burns done");
    for (int i = 5; i < 9; i++) begin
      setw(4'(i), 8'h01);
      burn;
    end
    setw(4'h9, 8'h01);
    expect_sub(SUB_CHECK, 24'h100000);
    expect_sub(SUB_WRITE, 24'h100000);
    $display("test slots done");
    // One manufacturing byte, checksum ~(70+00+5A), length 1 + 4
    u_host.sub(SUB_MFG, r6);
    u_host.wr_byte(7'h40, 8'h5A);
    u_host.wr_byte(7'h60, 8'h35);
    u_host.wr_byte(7'h61, 8'h05);
    repeat (4 * SLOW) @(posedge clk);
    #1;
    `CHK(busy, 1'b1)
    repeat (8) @(posedge clk);
    u_host.sub(SUB_MFG, r6);
    `CHK({r6[1], r6[2], r6[5]}, 24'h085A35)
    fst = 8'h5A;
    for (int i = 0; i < 3; i++) begin
      {fpe, fse, uv} = (i == 0) ? 3'b111 : {i[1], 2'b10};
      @(posedge clk) #1;
      pf = 1'b1;
      @(posedge clk) #1;
      pf = 1'b0;
      repeat (SLOW + 4) @(posedge clk);
      #1;
      `CHK(fsv, i == 2 ? 8'h5A : 8'h00)
    end
    $display("test fault done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
